// ===== src/oscillator_control_regs.sv
// oscillator control registers with wishbone slave, gating and enable handshake
`timescale 1ns/100ps
module oscillator_control_regs #(
   parameter int NUM_REQ = 4
) (
   input wire logic clk_i, // bus clock, 25 MHz
   input wire logic rst_i, // synchronous reset, high
   input wire logic wb_cyc_i, // wishbone cycle
   input wire logic wb_stb_i, // wishbone strobe
   input wire logic wb_we_i, // wishbone write
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic [4:0] nvm_ulp_calibration_value_i, // factory low-power calibration
   input wire logic [11:0] nvm_8m_calibration_value_i, // factory 8 MHz calibration
   input wire logic [1:0] nvm_8m_frequency_range_i, // factory 8 MHz range
   input wire logic standby_i, // standby sleep active
   input wire logic [NUM_REQ-1:0] req_8m_i, // peripheral requests, 8 MHz
   input wire logic [NUM_REQ-1:0] req_frequency_locked_loop_i, // peripheral requests, loop
   output logic [4:0] ulp_calibration_value_o, // low-power calibration
   output logic internal_8mhz_osc_run_o, // 8 MHz oscillator run
   output logic [1:0] internal_8mhz_osc_frequency_range_o, // 8 MHz range
   output logic [11:0] internal_8mhz_osc_calibration_value_o, // 8 MHz calibration
   output logic [3:0] internal_8mhz_osc_div_o, // 8 MHz division factor
   output logic frequency_locked_loop_run_o, // loop oscillator run
   output logic frequency_locked_loop_enable_o, // loop enable after sync
   output logic frequency_locked_loop_closed_loop_o, // loop closed-loop mode
   output logic frequency_locked_loop_stable_o, // freeze fine after lock
   output logic frequency_locked_loop_quick_lock_dis_o, // quick lock off
   output logic frequency_locked_loop_chill_dis_o, // chill cycle off
   output logic frequency_locked_loop_lose_lock_o // one-cycle drop-lock pulse
);

   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic cal_loaded;
      logic ulp_lock;
      logic [4:0] ulp_cal;
      logic [1:0] frequency_range;
      logic [11:0] cal8;
      logic [1:0] prescaler_select;
      logic [3:0] div;
      logic od8;
      logic rs8;
      osc_ctrl_pkg::osc_state_e st8;
      logic [3:0] cnt8;
      logic run8;
      logic [15:0] dctl;
      logic frequency_locked_loop_act;
      logic [3:0] dcnt;
      logic rundfll;
      logic prev_stby;
      logic slept_stop;
      logic lose_lock;
   } state_s;

   state_s s;
   state_s next;

   logic req_taken;
   logic wr;
   logic [5:0] word;
   logic hit_ulp;
   logic hit_8m;
   logic hit_frequency_locked_loop;
   logic req_any8;
   logic req_anyd;
   logic en_rd;

   assign req_taken = wb_cyc_i && wb_stb_i && !s.ack;
   assign wr = req_taken && wb_we_i;
   assign word = wb_adr_i[7:2];
   assign hit_ulp = word == osc_ctrl_pkg::ULP_OFFSET[7:2];
   assign hit_8m = word == osc_ctrl_pkg::INTERNAL_8MHZ_OSC_OFFSET[7:2];
   assign hit_frequency_locked_loop = word == osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET[7:2];
   assign req_any8 = |req_8m_i;
   assign req_anyd = |req_frequency_locked_loop_i;
   assign en_rd = (s.st8 == osc_ctrl_pkg::OSC_ON) || (s.st8 == osc_ctrl_pkg::OSC_STOPPING);

   always_comb begin
      next = s;
      // ack drops the cycle after it is given
      next.ack = wb_cyc_i && wb_stb_i && !s.ack;
      next.lose_lock = 1'b0;
      next.prev_stby = standby_i;

      if (wr && hit_ulp && wb_sel_i[0] && !s.ulp_lock) begin
         next.ulp_lock = wb_dat_i[osc_ctrl_pkg::ULP_LOCK_BIT];
         next.ulp_cal = wb_dat_i[osc_ctrl_pkg::ULP_CAL_W-1:0];
      end

      if (wr && hit_8m) begin
         if (wb_sel_i[3]) begin
            next.frequency_range = wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_FREQUENCY_RANGE_LSB +: 2];
            next.cal8[11:8] = wb_dat_i[27:24];
         end
         if (wb_sel_i[2]) begin
            next.cal8[7:0] = wb_dat_i[23:16];
         end
         if (wb_sel_i[1]) begin
            next.prescaler_select = wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_PRESCALER_SELECT_LSB +: 2];
         end
         if (wb_sel_i[0]) begin
            next.od8 = wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_OD_BIT];
            next.rs8 = wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_RS_BIT];
         end
      end

      // startup load
      // the load wins over a bus write in the first cycle after reset
      if (!s.cal_loaded) begin
         next.cal_loaded = 1'b1;
         next.ulp_cal = nvm_ulp_calibration_value_i;
         next.frequency_range = nvm_8m_frequency_range_i;
         next.cal8 = nvm_8m_calibration_value_i;
      end

      next.div = 4'h1 << next.prescaler_select;

      // transitions ignore enable writes
      // an enable write while starting or stopping is dropped, so software must poll
      unique case (s.st8)
         osc_ctrl_pkg::OSC_OFF: begin
            if (wr && hit_8m && wb_sel_i[0] && wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_EN_BIT]) begin
               next.st8 = osc_ctrl_pkg::OSC_STARTING;
               next.cnt8 = 4'h0;
            end
         end
         osc_ctrl_pkg::OSC_STARTING: begin
            if (s.cnt8 == osc_ctrl_pkg::SYNC_CYCLES - 4'h1) begin
               next.st8 = osc_ctrl_pkg::OSC_ON;
               next.cnt8 = 4'h0;
            end else begin
               next.cnt8 = s.cnt8 + 4'h1;
            end
         end
         osc_ctrl_pkg::OSC_ON: begin
            if (wr && hit_8m && wb_sel_i[0] && !wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_EN_BIT]) begin
               next.st8 = osc_ctrl_pkg::OSC_STOPPING;
               next.cnt8 = 4'h0;
            end
         end
         osc_ctrl_pkg::OSC_STOPPING: begin
            if (s.cnt8 == osc_ctrl_pkg::SYNC_CYCLES - 4'h1) begin
               next.st8 = osc_ctrl_pkg::OSC_OFF;
               next.cnt8 = 4'h0;
            end else begin
               next.cnt8 = s.cnt8 + 4'h1;
            end
         end
      endcase

      next.run8 = (s.st8 != osc_ctrl_pkg::OSC_OFF) && (!standby_i || s.rs8)
         && (!s.od8 || req_any8);

      // loop enable reads back at once
      if (wr && hit_frequency_locked_loop) begin
         if (wb_sel_i[0]) begin
            next.dctl[7:0] = wb_dat_i[7:0] & osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_WMASK[7:0];
         end
         if (wb_sel_i[1]) begin
            next.dctl[15:8] = wb_dat_i[15:8] & osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_WMASK[15:8];
         end
      end

      if (s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_EN_BIT] != s.frequency_locked_loop_act) begin
         if (s.dcnt == osc_ctrl_pkg::SYNC_CYCLES - 4'h1) begin
            next.frequency_locked_loop_act = s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_EN_BIT];
            next.dcnt = 4'h0;
         end else begin
            next.dcnt = s.dcnt + 4'h1;
         end
      end else begin
         next.dcnt = 4'h0;
      end

      next.rundfll = s.frequency_locked_loop_act && (!s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OD_BIT] || req_anyd);

      // lose lock on wake
      // only a stop seen during sleep counts; a stop in active mode keeps locks
      if (standby_i && !s.rundfll) begin
         next.slept_stop = 1'b1;
      end
      if (s.prev_stby && !standby_i) begin
         next.lose_lock = s.slept_stop && s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_LOSE_LOCK_AFTER_WAKE_BIT];
         next.slept_stop = 1'b0;
      end

      // read mux; unmapped words read as zero and ignore writes
      next.rdata = 32'h0000_0000;
      if (req_taken && !wb_we_i) begin
         if (hit_ulp) begin
            next.rdata = {24'h00_0000, s.ulp_lock, 2'h0, s.ulp_cal};
         end else if (hit_8m) begin
            next.rdata = {s.frequency_range, 2'h0, s.cal8, 6'h00, s.prescaler_select, s.od8, s.rs8,
               4'h0, en_rd, 1'b0};
         end else if (hit_frequency_locked_loop) begin
            next.rdata = {16'h0000, s.dctl};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s.ack <= 1'b0;
         s.rdata <= 32'h0000_0000;
         s.cal_loaded <= 1'b0;
         s.ulp_lock <= 1'b0;
         s.ulp_cal <= 5'h00;
         s.frequency_range <= 2'h0;
         s.cal8 <= 12'h000;
         s.prescaler_select <= osc_ctrl_pkg::INTERNAL_8MHZ_OSC_PRESCALER_SELECT_RST;
         s.div <= 4'h8;
         s.od8 <= osc_ctrl_pkg::INTERNAL_8MHZ_OSC_OD_RST;
         s.rs8 <= osc_ctrl_pkg::INTERNAL_8MHZ_OSC_RS_RST;
         // enable resets set, so the oscillator comes up through its start delay
         s.st8 <= osc_ctrl_pkg::OSC_STARTING;
         s.cnt8 <= 4'h0;
         s.run8 <= 1'b0;
         s.dctl <= osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_CTRL_RST;
         s.frequency_locked_loop_act <= 1'b0;
         s.dcnt <= 4'h0;
         s.rundfll <= 1'b0;
         s.prev_stby <= 1'b0;
         s.slept_stop <= 1'b0;
         s.lose_lock <= 1'b0;
      end else begin
         s <= next;
      end
   end

   assign wb_ack_o = s.ack;
   assign wb_dat_o = s.rdata;
   assign ulp_calibration_value_o = s.ulp_cal;
   assign internal_8mhz_osc_run_o = s.run8;
   assign internal_8mhz_osc_frequency_range_o = s.frequency_range;
   assign internal_8mhz_osc_calibration_value_o = s.cal8;
   assign internal_8mhz_osc_div_o = s.div;
   assign frequency_locked_loop_run_o = s.rundfll;
   assign frequency_locked_loop_enable_o = s.frequency_locked_loop_act;
   assign frequency_locked_loop_closed_loop_o = s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_MODE_BIT];
   assign frequency_locked_loop_stable_o = s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_STABLE_BIT];
   assign frequency_locked_loop_quick_lock_dis_o = s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_QUICK_LOCK_DISABLE_BIT];
   assign frequency_locked_loop_chill_dis_o = s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_CHILL_CYCLE_DISABLE_BIT];
   assign frequency_locked_loop_lose_lock_o = s.lose_lock;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_lock_hold;
      (s.ulp_lock && wr && hit_ulp && wb_sel_i[0]) |=> $stable(ulp_calibration_value_o) && s.ulp_lock;
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("locked register was written");
   property p_lock_sticky;
      s.ulp_lock |=> s.ulp_lock;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit cleared");
   property p_ulp_load;
      $fell(rst_i) |=> ulp_calibration_value_o == $past(nvm_ulp_calibration_value_i);
   endproperty
   a_ulp_load: assert property (p_ulp_load) else $error("low-power calibration not loaded");
   property p_8m_load;
      $fell(rst_i) |=> internal_8mhz_osc_frequency_range_o == $past(nvm_8m_frequency_range_i)
         && internal_8mhz_osc_calibration_value_o == $past(nvm_8m_calibration_value_i);
   endproperty
   a_8m_load: assert property (p_8m_load) else $error("8 MHz trim not loaded");
   property p_prescaler_select;
      internal_8mhz_osc_div_o == {s.prescaler_select == 2'h3, s.prescaler_select == 2'h2, s.prescaler_select == 2'h1, s.prescaler_select == 2'h0};
   endproperty
   a_prescaler_select: assert property (p_prescaler_select) else $error("prescaler factor wrong");
   property p_on_demand_a_stop;
      (s.od8 && !req_any8) |=> !internal_8mhz_osc_run_o;
   endproperty
   a_on_demand_a_stop: assert property (p_on_demand_a_stop) else $error("ran without request");
   property p_always_on;
      (!s.od8 && s.st8 == osc_ctrl_pkg::OSC_ON && !standby_i) |=> internal_8mhz_osc_run_o;
   endproperty
   a_always_on: assert property (p_always_on) else $error("enabled oscillator stopped");
   property p_stby_off;
      (standby_i && !s.rs8) |=> !internal_8mhz_osc_run_o;
   endproperty
   a_stby_off: assert property (p_stby_off) else $error("ran in standby");
   property p_stby_run;
      (standby_i && s.rs8 && s.st8 == osc_ctrl_pkg::OSC_ON && (!s.od8 || req_any8))
         |=> internal_8mhz_osc_run_o;
   endproperty
   a_stby_run: assert property (p_stby_run) else $error("stopped in standby");
   sequence s_start8;
      s.st8 == osc_ctrl_pkg::OSC_OFF && wr && hit_8m && wb_sel_i[0]
         && wb_dat_i[osc_ctrl_pkg::INTERNAL_8MHZ_OSC_EN_BIT];
   endsequence
   sequence s_settle8;
      (!en_rd)[*3] ##1 en_rd;
   endsequence
   property p_en_handshake;
      s_start8 |=> s_settle8;
   endproperty
   a_en_handshake: assert property (p_en_handshake) else $error("enable readback wrong");
   property p_frequency_locked_loop_readback;
      (wr && hit_frequency_locked_loop && wb_sel_i[0])
         |=> s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_EN_BIT] == $past(wb_dat_i[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_EN_BIT]);
   endproperty
   a_frequency_locked_loop_readback: assert property (p_frequency_locked_loop_readback) else $error("enable not read back");
   sequence s_frequency_locked_loop_lag;
      (!frequency_locked_loop_enable_o)[*3] ##1 frequency_locked_loop_enable_o;
   endsequence
   property p_frequency_locked_loop_delay;
      ($rose(s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_EN_BIT]) && !frequency_locked_loop_enable_o) |-> s_frequency_locked_loop_lag;
   endproperty
   a_frequency_locked_loop_delay: assert property (p_frequency_locked_loop_delay) else $error("loop enable delay wrong");
   property p_lose_lock;
      (s.prev_stby && !standby_i && s.slept_stop)
         |=> frequency_locked_loop_lose_lock_o == $past(s.dctl[osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_LOSE_LOCK_AFTER_WAKE_BIT]);
   endproperty
   a_lose_lock: assert property (p_lose_lock) else $error("lock drop on wake wrong");
   property p_frequency_locked_loop_reset;
      $fell(rst_i) |-> s.dctl == osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_CTRL_RST;
   endproperty
   a_frequency_locked_loop_reset: assert property (p_frequency_locked_loop_reset) else $error("loop control reset wrong");

endmodule

// ===== inc/osc_ctrl_pkg.sv
// shared constants for the oscillator control register block
package osc_ctrl_pkg;
   // register byte offsets
   localparam logic [7:0] ULP_OFFSET = 8'h1C;
   localparam logic [7:0] INTERNAL_8MHZ_OSC_OFFSET = 8'h20;
   localparam logic [7:0] FREQUENCY_LOCKED_LOOP_OFFSET = 8'h24;
   // ultra-low-power oscillator fields
   localparam int ULP_LOCK_BIT = 7;
   localparam int ULP_CAL_W = 5;
   // 8 MHz oscillator fields
   localparam int INTERNAL_8MHZ_OSC_FREQUENCY_RANGE_LSB = 30;
   localparam int INTERNAL_8MHZ_OSC_CAL_LSB = 16;
   localparam int INTERNAL_8MHZ_OSC_CAL_W = 12;
   localparam int INTERNAL_8MHZ_OSC_PRESCALER_SELECT_LSB = 8;
   localparam int INTERNAL_8MHZ_OSC_OD_BIT = 7;
   localparam int INTERNAL_8MHZ_OSC_RS_BIT = 6;
   localparam int INTERNAL_8MHZ_OSC_EN_BIT = 1;
   localparam logic [1:0] INTERNAL_8MHZ_OSC_PRESCALER_SELECT_RST = 2'h3;
   localparam logic INTERNAL_8MHZ_OSC_OD_RST = 1'b1;
   localparam logic INTERNAL_8MHZ_OSC_RS_RST = 1'b0;
   // locked-loop control fields
   localparam int FREQUENCY_LOCKED_LOOP_QUICK_LOCK_DISABLE_BIT = 9;
   localparam int FREQUENCY_LOCKED_LOOP_CHILL_CYCLE_DISABLE_BIT = 8;
   localparam int FREQUENCY_LOCKED_LOOP_OD_BIT = 7;
   localparam int FREQUENCY_LOCKED_LOOP_LOSE_LOCK_AFTER_WAKE_BIT = 4;
   localparam int FREQUENCY_LOCKED_LOOP_STABLE_BIT = 3;
   localparam int FREQUENCY_LOCKED_LOOP_MODE_BIT = 2;
   localparam int FREQUENCY_LOCKED_LOOP_EN_BIT = 1;
   localparam logic [15:0] FREQUENCY_LOCKED_LOOP_CTRL_RST = 16'h0080;
   localparam logic [15:0] FREQUENCY_LOCKED_LOOP_WMASK = 16'h039E;
   // enable synchronisation delay in bus clocks
   localparam logic [3:0] SYNC_CYCLES = 4'h3;
   typedef enum logic [1:0] {
      OSC_OFF,
      OSC_STARTING,
      OSC_ON,
      OSC_STOPPING
   } osc_state_e;
endpackage

// ===== testbench/oscillator_control_regs_bench.sv
// self-checking bench for the oscillator control register block
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin total_checks++; if ((got) !== (exp)) begin fails++; $display("MISMATCH %0t %s", $time, msg); end end
module oscillator_control_regs_bench;
   localparam int LIMIT = 4000;
   localparam logic [1:0] FR = 2'h2;
   localparam logic [11:0] CAL8 = 12'hA5C;
   localparam logic [4:0] CALU = 5'h13;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, standby_i;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i, req_8m_i, req_frequency_locked_loop_i, internal_8mhz_osc_div_o;
   logic [31:0] wb_dat_i, wb_dat_o, rd;
   logic [4:0] ulp_calibration_value_o;
   logic [4:0] nvm_ulp;
   logic [1:0] internal_8mhz_osc_frequency_range_o;
   logic [11:0] internal_8mhz_osc_calibration_value_o;
   logic internal_8mhz_osc_run_o, frequency_locked_loop_run_o, frequency_locked_loop_enable_o, frequency_locked_loop_closed_loop_o, frequency_locked_loop_stable_o;
   logic frequency_locked_loop_quick_lock_dis_o, frequency_locked_loop_chill_dis_o, frequency_locked_loop_lose_lock_o;
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;
   int pulses = 0;

   oscillator_control_regs #(.NUM_REQ(4)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nvm_ulp_calibration_value_i(nvm_ulp),
      .nvm_8m_calibration_value_i(CAL8), .nvm_8m_frequency_range_i(FR), .standby_i(standby_i),
      .req_8m_i(req_8m_i), .req_frequency_locked_loop_i(req_frequency_locked_loop_i), .ulp_calibration_value_o(ulp_calibration_value_o),
      .internal_8mhz_osc_run_o(internal_8mhz_osc_run_o), .internal_8mhz_osc_frequency_range_o(internal_8mhz_osc_frequency_range_o),
      .internal_8mhz_osc_calibration_value_o(internal_8mhz_osc_calibration_value_o), .internal_8mhz_osc_div_o(internal_8mhz_osc_div_o), .frequency_locked_loop_run_o(frequency_locked_loop_run_o),
      .frequency_locked_loop_enable_o(frequency_locked_loop_enable_o), .frequency_locked_loop_closed_loop_o(frequency_locked_loop_closed_loop_o),
      .frequency_locked_loop_stable_o(frequency_locked_loop_stable_o), .frequency_locked_loop_quick_lock_dis_o(frequency_locked_loop_quick_lock_dis_o),
      .frequency_locked_loop_chill_dis_o(frequency_locked_loop_chill_dis_o), .frequency_locked_loop_lose_lock_o(frequency_locked_loop_lose_lock_o));

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // a hung handshake ends here rather than spinning forever
   always @(posedge clk_i) begin
      cycles++;
      if (frequency_locked_loop_lose_lock_o === 1'b1) pulses++;
      if (cycles == LIMIT) begin
         fails++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      wait_cyc(6);
   endtask

   // single classic cycle: hold everything until ack is sampled high
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] dat);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= dat;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      wb_xfer(1'b1, adr, 4'hF, dat);
   endtask

   task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
      wb_xfer(1'b0, adr, 4'h0, 32'h0);
      `CHK(rd, exp, "register read")
   endtask

   function automatic logic [31:0] osc_word(input logic [1:0] p, input logic od,
                                            input logic rs, input logic en);
      return {FR, 2'h0, CAL8, 6'h0, p, od, rs, 4'h0, en, 1'b0};
   endfunction

   task automatic run_case(input logic od, input logic rs, input logic sb,
                           input logic [3:0] req, input logic exp);
      wr(internal_8mhz_osc_pkg_off(), osc_word(2'h0, od, rs, 1'b1));
      standby_i <= sb;
      req_8m_i <= req;
      wait_cyc(3);
      `CHK(internal_8mhz_osc_run_o, exp, "8 MHz run gating")
   endtask

   function automatic logic [7:0] internal_8mhz_osc_pkg_off();
      return osc_ctrl_pkg::INTERNAL_8MHZ_OSC_OFFSET;
   endfunction

   task automatic wake_case(input logic [31:0] ctrl, input int exp);
      wr(osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, ctrl);
      repeat (5) @(posedge clk_i);
      standby_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      pulses = 0;
      standby_i <= 1'b0;
      wait_cyc(4);
      `CHK(pulses, exp, "lose lock pulse count")
   endtask

   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
      standby_i = 1'b0;
      nvm_ulp = CALU;
      req_8m_i = 4'h0;
      req_frequency_locked_loop_i = 4'h0;
      do_reset();
      rchk(osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, 32'h0000_0080); // loop reset value
      rchk(internal_8mhz_osc_pkg_off(), osc_word(2'h3, 1'b1, 1'b0, 1'b1)); // trims and reset
      `CHK(internal_8mhz_osc_calibration_value_o, CAL8, "8 MHz trim") // trim load
      `CHK(internal_8mhz_osc_frequency_range_o, FR, "8 MHz band") // band load
      `CHK(ulp_calibration_value_o, CALU, "low-power trim") // trim load
      rchk(8'h10, 32'h0); // unmapped word reads zero
      for (int p = 0; p < 4; p++) begin
         wr(internal_8mhz_osc_pkg_off(), osc_word(p[1:0], 1'b0, 1'b0, 1'b1));
         wait_cyc(1);
         `CHK(internal_8mhz_osc_div_o, 4'h1 << p, "prescaler factor") // divide setting
      end
      // enable handshake: status lags the written value
      wr(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b0));
      rchk(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b1)); // still stopping
      wait_cyc(6);
      rchk(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b0)); // fully off
      `CHK(internal_8mhz_osc_run_o, 1'b0, "stopped oscillator") // disabled stays off
      wr(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b1)); // enable only once off
      rchk(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b0)); // still starting
      wait_cyc(6);
      rchk(internal_8mhz_osc_pkg_off(), osc_word(2'h0, 1'b0, 1'b0, 1'b1)); // fully on
      run_case(1'b0, 1'b0, 1'b0, 4'h0, 1'b1); // free running
      run_case(1'b0, 1'b0, 1'b1, 4'h0, 1'b0); // standby stop
      run_case(1'b1, 1'b0, 1'b1, 4'h4, 1'b0); // stop despite request
      run_case(1'b0, 1'b1, 1'b1, 4'h0, 1'b1); // kept in standby
      run_case(1'b1, 1'b1, 1'b1, 4'h0, 1'b0); // gated in standby
      run_case(1'b1, 1'b1, 1'b1, 4'h2, 1'b1); // requested in standby
      run_case(1'b1, 1'b0, 1'b0, 4'h0, 1'b0); // no request
      run_case(1'b1, 1'b0, 1'b0, 4'h8, 1'b1); // single request on bit 3
      // low-power register locking
      wr(osc_ctrl_pkg::ULP_OFFSET, 32'h0000_000A);
      rchk(osc_ctrl_pkg::ULP_OFFSET, 32'h0000_000A); // writable later
      wr(osc_ctrl_pkg::ULP_OFFSET, 32'h0000_0085);
      wr(osc_ctrl_pkg::ULP_OFFSET, 32'h0000_001F);
      rchk(osc_ctrl_pkg::ULP_OFFSET, 32'h0000_0085); // write ignored
      `CHK(ulp_calibration_value_o, 5'h05, "locked trim output") // lock holds
      // loop control fields and delayed enable
      wr(osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, 32'h0000_039E);
      `CHK(frequency_locked_loop_enable_o, 1'b0, "loop enable early") // sync delay
      rchk(osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, 32'h0000_039E); // immediate readback
      `CHK({frequency_locked_loop_quick_lock_dis_o, frequency_locked_loop_chill_dis_o}, 2'h3, "lock options")
      `CHK({frequency_locked_loop_stable_o, frequency_locked_loop_closed_loop_o}, 2'h3, "loop mode")
      wait_cyc(4);
      `CHK({frequency_locked_loop_enable_o, frequency_locked_loop_run_o}, 2'h2, "loop without request") // gated
      @(posedge clk_i);
      req_frequency_locked_loop_i <= 4'h1;
      wait_cyc(3);
      `CHK(frequency_locked_loop_run_o, 1'b1, "loop with request") // request runs loop
      @(posedge clk_i);
      req_frequency_locked_loop_i <= 4'h0;
      wake_case(32'h0000_039E, 1); // lock lost
      wake_case(32'h0000_038E, 0); // lock kept
      wb_xfer(1'b1, osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, 4'h1, 32'h0000_0000);
      rchk(osc_ctrl_pkg::FREQUENCY_LOCKED_LOOP_OFFSET, 32'h0000_0300); // upper lane kept
      // a new factory trim only shows after the next reset
      nvm_ulp <= 5'h0C;
      do_reset();
      rchk(osc_ctrl_pkg::ULP_OFFSET, {27'h0, 5'h0C}); // lock cleared, trim reloaded
      give_verdict();
   end
endmodule
